/* hdl/sleep_timer_pkg.sv */
// Package with constants and types for the low-power sleep timer
`default_nettype none
package sleep_timer_pkg;
  // Register addresses on the special function register bus
  localparam logic [7:0] ADDR_COUNT_LOW = 8'h95;
  localparam logic [7:0] ADDR_COUNT_MID = 8'h96;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h97;
  // Widths
  localparam int COUNT_W = 24;
  localparam int BYTE_W = 8;
  // Reset values and the unmapped read value
  localparam logic [23:0] COUNT_RESET = 24'h00_0000;
  localparam logic [23:0] COMPARE_RESET = 24'h0F_FFFF;
  localparam logic [7:0] STAGE_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // Byte field positions inside the 24-bit value
  localparam int LOW_LSB = 0;
  localparam int MID_LSB = 8;
  localparam int HIGH_LSB = 16;
  // Power modes, driven by the power manager
  typedef enum logic [1:0] {
    power_mode_active = 2'b00,
    power_mode_light_sleep = 2'b01,
    power_mode_mid_sleep = 2'b10,
    power_mode_deep_sleep = 2'b11
  } power_mode_t;
  // Low-clock edge tracker states
  typedef enum logic [1:0] {
    lp_idle_low = 2'b00,
    lp_seen_high = 2'b01
  } lp_edge_t;
endpackage : sleep_timer_pkg
`default_nettype wire

/* hdl/lp_clock_tick.sv */
// Synchroniser and rising-edge detector for the 32 kHz low-power clock
`default_nettype none
module lp_clock_tick
  import sleep_timer_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic lp_clk_pin,
  output logic lp_tick
);
  // Two-stage synchroniser; only sync2 reads sync1
  logic sync1_ff;
  logic sync2_ff;
  // Edge tracker state
  lp_edge_t edge_ff;
  lp_edge_t nxt_edge;
  logic nxt_sync1;
  logic nxt_sync2;
  logic nxt_tick;
  logic tick_ff;

  // Next-state logic: one tick per rising edge of the synchronised clock
  always_comb
  begin
    nxt_sync1 = lp_clk_pin;
    nxt_sync2 = sync1_ff;
    nxt_tick = 1'b0;
    nxt_edge = edge_ff;
    case (edge_ff)
      lp_idle_low:
      begin
        // Rising edge seen
        if (sync2_ff)
        begin
          nxt_tick = 1'b1;
          nxt_edge = lp_seen_high;
        end
      end
      lp_seen_high:
      begin
        // Wait for the low phase
        if (!sync2_ff)
          nxt_edge = lp_idle_low;
      end
      default:
        nxt_edge = lp_idle_low;
    endcase
  end

  // Registers; clock enable freezes everything
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      edge_ff <= lp_idle_low;
      tick_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      edge_ff <= nxt_edge;
      tick_ff <= nxt_tick;
    end
  end

  // Tick is qualified by the enable so a frozen block never double counts
  assign lp_tick = tick_ff & clk_en;
endmodule : lp_clock_tick
`default_nettype wire

/* hdl/low_power_sleep_timer.sv */
// Sleep timer: 24-bit low-clock counter with compare, wake and DMA trigger
`default_nettype none
module low_power_sleep_timer
  import sleep_timer_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic lp_clk_pin,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [1:0] power_mode,
  input wire logic sleep_match_irq_enable,
  input wire logic sleep_match_flag_clear,
  output logic sleep_match_flag,
  output logic sleep_wake_irq,
  output logic dma_trigger,
  output logic wake_request
);
  // Address decode, used for both reads and writes
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  // One pulse per low-clock rising edge
  logic lp_tick;

  // Counter and compare state
  logic [23:0] count_ff;
  logic [23:0] nxt_count;
  logic [23:0] compare_ff;
  logic [23:0] nxt_compare;
  // Staged compare bytes waiting for the low-byte write
  logic [7:0] stage_mid_ff;
  logic [7:0] nxt_stage_mid;
  logic [7:0] stage_high_ff;
  logic [7:0] nxt_stage_high;
  // Read holding latches for middle and high count bytes
  logic [7:0] hold_mid_ff;
  logic [7:0] nxt_hold_mid;
  logic [7:0] hold_high_ff;
  logic [7:0] nxt_hold_high;
  // Event outputs, flag and read data
  logic flag_ff;
  logic nxt_flag;
  logic dma_ff;
  logic nxt_dma;
  logic wake_ff;
  logic nxt_wake;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  // Combinational helpers
  logic advance;
  logic [23:0] count_plus;
  logic match_hit;
  power_mode_t mode;

  // Low clock arrives from a pin; synchronised in the leaf
  lp_clock_tick u_tick (
    .clock(clock),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .lp_clk_pin(lp_clk_pin),
    .lp_tick(lp_tick)
  );

  assign mode = power_mode_t'(power_mode);

  // Counter and compare next-state logic
  always_comb
  begin
    // Halted only in deep sleep; no software control exists
    advance = lp_tick && (mode != power_mode_deep_sleep);
    // Natural 24-bit overflow gives the wrap to zero
    count_plus = count_ff + 24'h00_0001;
    nxt_count = advance ? count_plus : count_ff;
    // A match is taken when the count steps onto the compare value, so
    // one event per match instead of one per system clock
    match_hit = advance && (count_plus == compare_ff);
    nxt_compare = compare_ff;
    nxt_stage_mid = stage_mid_ff;
    nxt_stage_high = stage_high_ff;
    // A low-byte write in a tick cycle lands after this step's match test,
    // so the old compare still decides that one step
    if (sfr_wr)
    begin
      // Upper bytes only staged
      if (hit(sfr_addr, ADDR_COUNT_MID))
        nxt_stage_mid = sfr_wdata;
      if (hit(sfr_addr, ADDR_COUNT_HIGH))
        nxt_stage_high = sfr_wdata;
      // Low byte write commits the whole 24-bit compare at once
      if (hit(sfr_addr, ADDR_COUNT_LOW))
        nxt_compare = {stage_high_ff, stage_mid_ff, sfr_wdata};
    end
  end

  // Read path next-state logic
  always_comb
  begin
    nxt_hold_mid = hold_mid_ff;
    nxt_hold_high = hold_high_ff;
    nxt_rdata = rdata_ff;
    // Reads and writes in one cycle both act; reads never see the compare
    if (sfr_rd)
    begin
      if (hit(sfr_addr, ADDR_COUNT_LOW))
      begin
        // Freeze the upper bytes so a multi-byte read is coherent
        nxt_hold_mid = count_ff[MID_LSB +: BYTE_W];
        nxt_hold_high = count_ff[HIGH_LSB +: BYTE_W];
        nxt_rdata = count_ff[LOW_LSB +: BYTE_W];
      end
      else if (hit(sfr_addr, ADDR_COUNT_MID))
        nxt_rdata = hold_mid_ff;
      else if (hit(sfr_addr, ADDR_COUNT_HIGH))
        nxt_rdata = hold_high_ff;
      else
        nxt_rdata = UNMAPPED_READ;
    end
  end

  // Event next-state logic
  always_comb
  begin
    // Set wins over a clear in the same cycle
    if (match_hit)
      nxt_flag = 1'b1;
    else if (sleep_match_flag_clear)
      nxt_flag = 1'b0;
    else
      nxt_flag = flag_ff;
    // DMA trigger pulses on every match
    nxt_dma = match_hit;
    // Wake only from the two intermediate sleep modes
    nxt_wake = match_hit && ((mode == power_mode_light_sleep) || (mode == power_mode_mid_sleep));
  end

  // Counter, compare and staging registers; clock enable freezes them
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      count_ff <= COUNT_RESET;
      // Default compare lies far from zero, so no match right after reset
      compare_ff <= COMPARE_RESET;
      stage_mid_ff <= STAGE_RESET;
      stage_high_ff <= STAGE_RESET;
    end
    else if (clk_en)
    begin
      count_ff <= nxt_count;
      compare_ff <= nxt_compare;
      stage_mid_ff <= nxt_stage_mid;
      stage_high_ff <= nxt_stage_high;
    end
  end

  // Read holding latches and read data register
  always_ff @(posedge clock)
  begin
    // A low-byte read refreshes the latches for the next two reads
    if (sys_rst)
    begin
      hold_mid_ff <= STAGE_RESET;
      hold_high_ff <= STAGE_RESET;
      rdata_ff <= RDATA_RESET;
    end
    else if (clk_en)
    begin
      hold_mid_ff <= nxt_hold_mid;
      hold_high_ff <= nxt_hold_high;
      rdata_ff <= nxt_rdata;
    end
  end

  // Match flag and event pulse registers
  always_ff @(posedge clock)
  begin
    // Pulses last one enabled cycle; a frozen block holds them
    if (sys_rst)
    begin
      flag_ff <= 1'b0;
      dma_ff <= 1'b0;
      wake_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      flag_ff <= nxt_flag;
      dma_ff <= nxt_dma;
      wake_ff <= nxt_wake;
    end
  end

  // Outputs
  assign sfr_rdata = rdata_ff;
  assign sleep_match_flag = flag_ff;
  // Pending flag is kept regardless; the enable only gates the request
  assign sleep_wake_irq = flag_ff & sleep_match_irq_enable;
  assign dma_trigger = dma_ff;
  // Software is expected to wait for the low byte to move after a
  // compare write before sleeping; the commit here is immediate
  assign wake_request = wake_ff;
endmodule : low_power_sleep_timer
`default_nettype wire

/* tb/sleep_timer_properties.sv */
// Port assertions for the sleep timer
`default_nettype none
module sleep_timer_properties
  import sleep_timer_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic [1:0] power_mode,
  input wire logic sleep_match_irq_enable,
  input wire logic sleep_match_flag_clear,
  input wire logic sleep_match_flag,
  input wire logic sleep_wake_irq,
  input wire logic dma_trigger,
  input wire logic wake_request
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // A match event is a single-cycle trigger pulse
  sequence s_pulse;
    dma_trigger ##1 !dma_trigger;
  endsequence
  a_irq_gated: assert property (sleep_wake_irq == (sleep_match_flag && sleep_match_irq_enable))
    else $error("irq not flag and enable");
  a_dma_pulse: assert property (dma_trigger |-> s_pulse)
    else $error("dma trigger longer than one cycle");
  a_flag_cause: assert property ($rose(sleep_match_flag) |-> dma_trigger)
    else $error("flag rose without match");
  a_flag_sticky: assert property (sleep_match_flag && !sleep_match_flag_clear |=> sleep_match_flag)
    else $error("flag dropped without clear");
  a_clear_works: assert property (clk_en && sleep_match_flag_clear |=> !sleep_match_flag || dma_trigger)
    else $error("clear ignored");
  a_wake_mode: assert property (wake_request |-> dma_trigger && $past(power_mode) inside {2'h1, 2'h2})
    else $error("wake outside sleep");
  a_wake_match: assert property (dma_trigger && $past(power_mode) inside {2'h1, 2'h2} |-> wake_request)
    else $error("sleeping match gave no wake");
  a_deep_halt: assert property (power_mode == 2'h3 |=> !dma_trigger)
    else $error("event in deep sleep");
  a_unmapped_zero: assert property (clk_en && sfr_rd && !(sfr_addr inside {8'h95, 8'h96, 8'h97})
    |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  // A frozen block must hold its flag and read data
  a_freeze_hold: assert property (!clk_en |=> $stable(sleep_match_flag) && $stable(sfr_rdata))
    else $error("state moved while enable low");
endmodule : sleep_timer_properties
bind low_power_sleep_timer sleep_timer_properties i_props (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
  .sfr_addr(sfr_addr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .power_mode(power_mode),
  .sleep_match_irq_enable(sleep_match_irq_enable), .sleep_match_flag_clear(sleep_match_flag_clear),
  .sleep_match_flag(sleep_match_flag), .sleep_wake_irq(sleep_wake_irq), .dma_trigger(dma_trigger),
  .wake_request(wake_request));
`default_nettype wire

/* tb/sfr_host_model.sv */
// Host side of the register bus, one-cycle strobes
`default_nettype none
module sfr_host_model
(
  input wire logic clock,
  input wire logic [7:0] sfr_rdata,
  output logic [7:0] sfr_addr,
  output logic sfr_wr,
  output logic sfr_rd,
  output logic [7:0] sfr_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
  end
  // Write: low byte last commits the compare
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clock);
    sfr_wr = 1'b0;
    // Stale data inverted so nothing leans on it
    sfr_wdata = ~d;
  endtask : wr
  // Read: data is registered, taken one cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clock);
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask : rd
endmodule : sfr_host_model
`default_nettype wire

/* tb/low_power_sleep_timer_tb_top.sv */
// Self-checking bench for the sleep timer
`default_nettype none
module low_power_sleep_timer_tb_top
  import sleep_timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic lp_clk_pin = 1'b0;
  logic [1:0] power_mode = 2'b00;
  logic irq_en = 1'b0;
  logic flag_clr = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, b;
  logic sfr_wr, sfr_rd, flag, irq, dma, wake;
  logic [23:0] v;
  int miscompares = 0;
  int tests_run = 0;
  int wakes = 0;
  int dmas = 0;
  // Ordinary rows: ticks to send, count expected after them
  typedef struct {int n; logic [23:0] c;} row_t;
  row_t rows [3] = '{'{1, 24'h00_0001}, '{2, 24'h00_0003}, '{253, 24'h00_0100}};
  always #2.5 clock = ~clock;
  // Event pulses counted on the falling edge, away from the launching edge
  always @(negedge clock)
  begin
    if (wake)
      wakes++;
    if (dma)
      dmas++;
  end
  low_power_sleep_timer i_dut (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .lp_clk_pin(lp_clk_pin),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .power_mode(power_mode), .sleep_match_irq_enable(irq_en), .sleep_match_flag_clear(flag_clr),
    .sleep_match_flag(flag), .sleep_wake_irq(irq), .dma_trigger(dma), .wake_request(wake));
  sfr_host_model i_host (.clock(clock), .sfr_rdata(sfr_rdata), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata));
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
    tests_run++;
    if (s !== e)
    begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk
  // Low-clock steps, slow against the system clock
  task automatic step(input int n);
    repeat (n)
    begin
      @(negedge clock) lp_clk_pin = 1'b1;
      repeat (6) @(negedge clock);
      lp_clk_pin = 1'b0;
      repeat (6) @(negedge clock);
    end
  endtask : step
  // Low byte first so upper bytes are a coherent snapshot
  task automatic rdcount(output logic [23:0] c);
    i_host.rd(8'h95, c[7:0]);
    i_host.rd(8'h96, c[15:8]);
    i_host.rd(8'h97, c[23:16]);
  endtask : rdcount
  task automatic end_of_test();
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  // Watchdog well above the expected run length
  initial
  begin
    repeat (40000) @(posedge clock);
    miscompares++;
    end_of_test();
  end
  initial
  begin
    repeat (2) @(posedge clock);
    @(negedge clock) sys_rst = 1'b0;
    rdcount(v);
    chk("reset count", 24'h00_0000, v);
    $display("end reset");
    foreach (rows[i])
    begin
      step(rows[i].n);
      rdcount(v);
      chk("count", rows[i].c, v);
    end
    chk("no early match", 24'h00_0000, {23'h0, flag});
    $display("end rows");
    // Enable low: pin edges meanwhile must not count
    clk_en = 1'b0;
    step(2);
    clk_en = 1'b1;
    rdcount(v);
    chk("frozen count", 24'h00_0100, v);
    step(256);
    i_host.rd(8'h96, b);
    chk("held mid", 24'h00_0001, {16'h0, b});
    i_host.wr(8'h97, 8'h00);
    i_host.wr(8'h96, 8'h02);
    step(2);
    i_host.wr(8'h95, 8'h05);
    // A staged mid byte must not disturb the committed compare
    i_host.wr(8'h96, 8'h07);
    step(1);
    power_mode = 2'h2;
    irq_en = 1'b1;
    step(1);
    chk("flag before", 24'h00_0000, {23'h0, flag});
    step(1);
    chk("flag", 24'h00_0001, {23'h0, flag});
    chk("irq", 24'h00_0001, {23'h0, irq});
    chk("wakes", 24'h00_0001, 24'(wakes));
    chk("dma", 24'h00_0001, 24'(dmas));
    irq_en = 1'b0;
    @(negedge clock) flag_clr = 1'b1;
    chk("irq masked", 24'h00_0000, {23'h0, irq});
    chk("flag kept", 24'h00_0001, {23'h0, flag});
    @(negedge clock) flag_clr = 1'b0;
    chk("cleared", 24'h00_0000, {23'h0, flag});
    i_host.wr(8'h96, 8'h02);
    i_host.wr(8'h95, 8'h08);
    power_mode = 2'h3;
    step(3);
    power_mode = 2'h0;
    rdcount(v);
    chk("deep halt", 24'h00_0205, v);
    step(3);
    chk("active match", 24'h00_0001, {23'h0, flag});
    chk("no active wake", 24'h00_0001, 24'(wakes));
    chk("dma again", 24'h00_0002, 24'(dmas));
    @(negedge clock) flag_clr = 1'b1;
    @(negedge clock) flag_clr = 1'b0;
    i_host.wr(8'h95, 8'h0A);
    step(1);
    power_mode = 2'h1;
    step(1);
    chk("light wake", 24'h00_0002, 24'(wakes));
    i_host.rd(8'h94, b);
    chk("unmapped", 24'h00_0000, {16'h0, b});
    // Mid-run reset with a compare that would match after two ticks if kept
    i_host.wr(8'h96, 8'h00);
    i_host.wr(8'h95, 8'h02);
    @(negedge clock) sys_rst = 1'b1;
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    chk("reset flag", 24'h00_0000, {23'h0, flag});
    step(2);
    rdcount(v);
    chk("restart count", 24'h00_0002, v);
    chk("reset compare", 24'h00_0000, {23'h0, flag});
    $display("end awkward");
    end_of_test();
  end
endmodule : low_power_sleep_timer_tb_top
`default_nettype wire
